// file: hw/rtc_cal_pkg.sv
// Purpose: Constants shared by the calendar, alarm and serial access logic
// Assumes: 8-bit register file reached by a two-wire serial slave
// Notes: Time and date fields are BCD, except the weekday, which is 3-bit binary

package rtc_cal_pkg;

    // Serial slave address; write byte A2h, read byte A3h
    localparam logic [6:0] DEV_ADDR = 7'h51;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int SYNC_STAGES = 3;

    // Register offsets
    localparam logic [3:0] OFS_CTRL2 = 4'h1;
    localparam logic [3:0] OFS_SEC = 4'h2;
    localparam logic [3:0] OFS_MIN = 4'h3;
    localparam logic [3:0] OFS_HOUR = 4'h4;
    localparam logic [3:0] OFS_DAY = 4'h5;
    localparam logic [3:0] OFS_WDAY = 4'h6;
    localparam logic [3:0] OFS_MONTH = 4'h7;
    localparam logic [3:0] OFS_YEAR = 4'h8;
    localparam logic [3:0] OFS_AL_MIN = 4'h9;
    localparam logic [3:0] OFS_AL_HOUR = 4'ha;
    localparam logic [3:0] OFS_AL_DAY = 4'hb;
    localparam logic [3:0] OFS_AL_WDAY = 4'hc;

    // Field positions
    localparam int AF_BIT = 3;
    localparam int CENTURY_BIT = 7;
    localparam int ALARM_DIS_BIT = 7;

    // Writable bits of each register
    localparam logic [7:0] MSK_SEC = 8'h7f;
    localparam logic [7:0] MSK_MIN = 8'h7f;
    localparam logic [7:0] MSK_HOUR = 8'h3f;
    localparam logic [7:0] MSK_DAY = 8'h3f;
    localparam logic [7:0] MSK_WDAY = 8'h07;
    localparam logic [7:0] MSK_MONTH = 8'h1f;
    localparam logic [7:0] MSK_AL_MIN = 8'hff;
    localparam logic [7:0] MSK_AL_HOUR = 8'hbf;
    localparam logic [7:0] MSK_AL_DAY = 8'hbf;
    localparam logic [7:0] MSK_AL_WDAY = 8'h87;

    // Reset values
    localparam logic [7:0] RST_TIME = 8'h00;
    localparam logic [7:0] RST_DATE = 8'h01;
    localparam logic [7:0] RST_ALARM = 8'h80;

    // Counter limits in BCD
    localparam logic [7:0] SEC_MAX = 8'h59;
    localparam logic [7:0] HOUR_MAX = 8'h23;
    localparam logic [7:0] MONTH_MAX = 8'h12;
    localparam logic [7:0] YEAR_MAX = 8'h99;
    localparam logic [7:0] FEB = 8'h02;
    localparam logic [2:0] WDAY_MAX = 3'h6;

    // Oscillator and tick timing
    localparam int OSC_HZ = 32768;
    localparam int TICK_PERIOD_S = 1;
    localparam int TICK_DIV_DEFAULT = OSC_HZ * TICK_PERIOD_S;

endpackage : rtc_cal_pkg

// file: hw/osc_tick_source.sv
// Purpose: Divide the oscillator clock down to the one-second tick
// Assumes: Runs on the oscillator clock only
// Notes: The tick leaves as a toggle so the system side can cross it safely

`timescale 1ns/1ps
`default_nettype none

module osc_tick_source
#(
    parameter int TICK_DIV = rtc_cal_pkg::TICK_DIV_DEFAULT
)
(
    input wire logic clk_osc_i,
    input wire logic srst_i,
    output logic tick_tog_o
);
    import rtc_cal_pkg::*;

    logic [1:0] rst_sync;
    logic [31:0] div_cnt;
    wire osc_rst = rst_sync[1];
    wire div_end = (div_cnt == 32'(TICK_DIV - 1));

    // Reset level crossing into the oscillator domain
    always_ff @(posedge clk_osc_i)
    begin
        rst_sync <= {rst_sync[0], srst_i};
    end

    always_ff @(posedge clk_osc_i)
    begin
        if (osc_rst)
        begin
            div_cnt <= 32'h0;
            tick_tog_o <= 1'b0;
        end
        else if (div_end)
        begin
            div_cnt <= 32'h0;
            tick_tog_o <= ~tick_tog_o;
        end
        else
        begin
            div_cnt <= div_cnt + 32'h1;
        end
    end

endmodule : osc_tick_source

`default_nettype wire

// file: hw/calendar_date_alarm_core.sv
// Purpose: Calendar counters, alarm compare and serial register access
// Assumes: Two-wire serial master on SCL/SDA; oscillator clock on CLK_OSC_I
// Notes: Time is frozen while the device is addressed; one tick may wait
// Function
// RULE_01: Day of month is BCD, tens 0-3 in bits 5:4, units bits 3:0.
// RULE_02: February gets day 29 when BCD year divisible by 4, year 00 too.
// RULE_03: Weekday is 3-bit binary in bits 2:0, values 0 to 6.
// RULE_04: Weekday code is only a counter; meaning belongs to software.
// RULE_05: Century bit 7 of month register flips when year wraps 99 to 00.
// RULE_06: Century bit 0 means century x, 1 means x plus one.
// RULE_07: Month is BCD, tens bit 4, units bits 3:0, 01 to 12.
// RULE_08: Year is two BCD digits, tens bits 7:4, units bits 3:0.
// RULE_09: Time counters 02h to 08h do not advance during a bus access.
// RULE_10: One tick arriving during an access is held and applied afterwards.
// RULE_11: Master finishes each time access within one second.
// RULE_12: Master reads or writes seconds through years in one transaction.
// RULE_13: Master reads time: A2h, pointer 02h, restart, A3h, seven reads, stop.
// RULE_14: Enabled alarm fields with disable bit 0 compare against the time.
// RULE_15: Alarm hit flag sets on first full match and stays until cleared.
// RULE_16: After clearing, flag sets only when time next increments into match.
// RULE_17: Alarm fields with disable bit 1 are left out of the compare.
// RULE_18: Hours are BCD, tens 0-2 in bits 5:4; hour rollover advances day.
// RULE_19: Day wraps to 01 after month end; month wraps 12 to 01 and bumps year.
// RULE_20: Weekday advances once per day, wrapping 6 to 0.

`timescale 1ns/1ps
`default_nettype none

module calendar_date_alarm_core
#(
    parameter int TICK_DIV = rtc_cal_pkg::TICK_DIV_DEFAULT
)
(
    input wire logic CLK_SYS_I,
    input wire logic SRST_I,
    input wire logic CLK_OSC_I,
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_N_O,
    output logic ALARM_HIT_O
);
    import rtc_cal_pkg::*;

    typedef enum logic [6:0] {
        S_IDLE = 7'b0000001,
        S_ADDR = 7'b0000010,
        S_PTR = 7'b0000100,
        S_WDATA = 7'b0001000,
        S_RDATA = 7'b0010000,
        S_ACK = 7'b0100000,
        S_MACK = 7'b1000000
    } bus_state_e;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction : bcd_inc

    logic tick_tog;
    logic [SYNC_STAGES-1:0] sync_ff [3];
    logic filt [3];
    logic scl_p, sda_p, tog_p;
    bus_state_e state, after;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [3:0] ptr;
    logic sda_pull, mack_ok;
    logic [7:0] sec, min, hour, day, month, year;
    logic [2:0] wday;
    logic [7:0] al_min, al_hour, al_day, al_wday;
    logic pend, af, moved, match_old;

    osc_tick_source #(.TICK_DIV(TICK_DIV)) u_tick (
        .clk_osc_i(CLK_OSC_I),
        .srst_i(SRST_I),
        .tick_tog_o(tick_tog)
    );

    // Three-stage synchronisers; a change counts when stages two and three agree
    wire [2:0] raw_in = {tick_tog, SDA_I, SCL_I};
    generate
        for (genvar g = 0; g < 3; g++)
        begin : g_sync
            always_ff @(posedge CLK_SYS_I)
            begin
                sync_ff[g] <= {sync_ff[g][SYNC_STAGES-2:0], raw_in[g]};
                if (sync_ff[g][1] == sync_ff[g][2])
                begin
                    filt[g] <= sync_ff[g][2];
                end
            end
        end
    endgenerate

    wire scl_f = filt[0];
    wire sda_f = filt[1];
    wire scl_rise = scl_f & ~scl_p;
    wire scl_fall = ~scl_f & scl_p;
    wire bus_start = scl_f & scl_p & sda_p & ~sda_f;
    wire bus_stop = scl_f & scl_p & ~sda_p & sda_f;
    wire tick = filt[2] ^ tog_p;
    wire byte_in = scl_fall & (bitcnt == BITS_PER_BYTE);
    wire addr_hit = (shreg[7:1] == DEV_ADDR);
    wire wr_en = (state == S_WDATA) & byte_in;
    wire busy = (state != S_IDLE) & (state != S_ADDR);
    wire apply = pend & ~busy; // RULE_09

    // Read data selection
    wire [7:0] rd_data =
        (ptr == OFS_CTRL2) ? (8'(af) << AF_BIT) :
        (ptr == OFS_SEC) ? sec :
        (ptr == OFS_MIN) ? min :
        (ptr == OFS_HOUR) ? hour :
        (ptr == OFS_DAY) ? day :
        (ptr == OFS_WDAY) ? {5'h0, wday} :
        (ptr == OFS_MONTH) ? month :
        (ptr == OFS_YEAR) ? year :
        (ptr == OFS_AL_MIN) ? al_min :
        (ptr == OFS_AL_HOUR) ? al_hour :
        (ptr == OFS_AL_DAY) ? al_day :
        (ptr == OFS_AL_WDAY) ? al_wday : 8'h00;

    always_ff @(posedge CLK_SYS_I)
    begin
        scl_p <= scl_f;
        sda_p <= sda_f;
        tog_p <= filt[2];
    end

    // Serial slave
    always_ff @(posedge CLK_SYS_I)
    begin
        if (SRST_I)
        begin
            state <= S_IDLE;
            after <= S_IDLE;
            bitcnt <= 4'h0;
            shreg <= 8'h00;
            ptr <= 4'h0;
            sda_pull <= 1'b0;
            mack_ok <= 1'b0;
        end
        else if (bus_start)
        begin
            state <= S_ADDR;
            bitcnt <= 4'h0;
            sda_pull <= 1'b0;
        end
        else if (bus_stop)
        begin
            state <= S_IDLE;
            sda_pull <= 1'b0;
        end
        else
        begin
            case (state)
                S_ADDR, S_PTR, S_WDATA:
                begin
                    if (scl_rise)
                    begin
                        shreg <= {shreg[6:0], sda_f};
                        bitcnt <= bitcnt + 4'h1;
                    end
                    else if (byte_in)
                    begin
                        bitcnt <= 4'h0;
                        sda_pull <= 1'b1;
                        state <= S_ACK;
                        if (state == S_ADDR)
                        begin
                            after <= shreg[0] ? S_RDATA : S_PTR;
                            if (!addr_hit)
                            begin
                                sda_pull <= 1'b0;
                                state <= S_IDLE;
                            end
                        end
                        else if (state == S_PTR)
                        begin
                            ptr <= shreg[3:0];
                            after <= S_WDATA;
                        end
                        else
                        begin
                            ptr <= ptr + 4'h1;
                        end
                    end
                end
                S_ACK, S_MACK:
                begin
                    if (scl_rise)
                    begin
                        mack_ok <= ~sda_f;
                    end
                    else if (scl_fall)
                    begin
                        if (after == S_RDATA && (state == S_ACK || mack_ok))
                        begin
                            shreg <= {rd_data[6:0], 1'b0};
                            sda_pull <= ~rd_data[7];
                            bitcnt <= 4'h1;
                            state <= S_RDATA;
                        end
                        else
                        begin
                            sda_pull <= 1'b0;
                            state <= (state == S_ACK) ? after : S_IDLE;
                        end
                    end
                end
                S_RDATA:
                begin
                    if (byte_in)
                    begin
                        sda_pull <= 1'b0;
                        ptr <= ptr + 4'h1;
                        state <= S_MACK;
                    end
                    else if (scl_fall)
                    begin
                        sda_pull <= ~shreg[7];
                        shreg <= {shreg[6:0], 1'b0};
                        bitcnt <= bitcnt + 4'h1;
                    end
                end
                default:
                begin
                    sda_pull <= 1'b0;
                end
            endcase
        end
    end

    // Calendar carry chain
    wire leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                        : (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8); // RULE_02
    wire short_month = (month[4:0] == 5'h04) || (month[4:0] == 5'h06) ||
                       (month[4:0] == 5'h09) || (month[4:0] == 5'h11);
    wire [7:0] last_day = (month[4:0] == FEB[4:0]) ? (leap ? 8'h29 : 8'h28) :
                          short_month ? 8'h30 : 8'h31; // RULE_02
    wire sec_wrap = (sec >= SEC_MAX);
    wire min_wrap = (min >= SEC_MAX);
    wire hour_wrap = (hour >= HOUR_MAX);
    wire day_wrap = (day >= last_day);
    wire month_wrap = ({3'h0, month[4:0]} >= MONTH_MAX);
    wire year_wrap = (year >= YEAR_MAX);
    wire c_hour = sec_wrap & min_wrap;
    wire c_day = c_hour & hour_wrap; // RULE_18
    wire c_month = c_day & day_wrap;
    wire c_year = c_month & month_wrap;
    wire c_cent = c_year & year_wrap;

    wire [7:0] next_sec = sec_wrap ? RST_TIME : bcd_inc(sec);
    wire [7:0] next_min = !sec_wrap ? min : min_wrap ? RST_TIME : bcd_inc(min);
    wire [7:0] next_hour = !c_hour ? hour : hour_wrap ? RST_TIME : bcd_inc(hour); // RULE_18
    wire [7:0] next_day = !c_day ? day : day_wrap ? RST_DATE : bcd_inc(day); // RULE_19
    wire [2:0] next_wday = !c_day ? wday : (wday >= WDAY_MAX) ? 3'h0 : wday + 3'h1; // RULE_20
    wire [7:0] mon_inc = bcd_inc({3'h0, month[4:0]});
    wire [4:0] next_mon = !c_month ? month[4:0] : month_wrap ? RST_DATE[4:0] : mon_inc[4:0]; // RULE_19
    wire next_cent = month[CENTURY_BIT] ^ c_cent; // RULE_05
    wire [7:0] next_year = !c_year ? year : year_wrap ? RST_TIME : bcd_inc(year); // RULE_08

    // Time registers; writes only land while busy, increments only while idle or receiving the address byte
    always_ff @(posedge CLK_SYS_I)
    begin
        if (SRST_I)
        begin
            sec <= RST_TIME;
            min <= RST_TIME;
            hour <= RST_TIME;
            day <= RST_DATE;
            wday <= 3'h0;
            month <= RST_DATE;
            year <= RST_TIME;
        end
        else if (apply) // RULE_09
        begin
            sec <= next_sec;
            min <= next_min;
            hour <= next_hour;
            day <= next_day; // RULE_01
            wday <= next_wday; // RULE_03 RULE_04
            month <= {next_cent, 2'h0, next_mon}; // RULE_06 RULE_07
            year <= next_year;
        end
        else if (wr_en)
        begin
            if (ptr == OFS_SEC) sec <= shreg & MSK_SEC;
            if (ptr == OFS_MIN) min <= shreg & MSK_MIN;
            if (ptr == OFS_HOUR) hour <= shreg & MSK_HOUR;
            if (ptr == OFS_DAY) day <= shreg & MSK_DAY; // RULE_01
            if (ptr == OFS_WDAY) wday <= shreg[2:0]; // RULE_03
            if (ptr == OFS_MONTH) month <= shreg & (MSK_MONTH | (8'h01 << CENTURY_BIT)); // RULE_07
            if (ptr == OFS_YEAR) year <= shreg; // RULE_08
        end
    end

    // Alarm registers and pending tick
    always_ff @(posedge CLK_SYS_I)
    begin
        if (SRST_I)
        begin
            al_min <= RST_ALARM;
            al_hour <= RST_ALARM;
            al_day <= RST_ALARM;
            al_wday <= RST_ALARM;
            pend <= 1'b0;
        end
        else
        begin
            if (wr_en && ptr == OFS_AL_MIN) al_min <= shreg & MSK_AL_MIN;
            if (wr_en && ptr == OFS_AL_HOUR) al_hour <= shreg & MSK_AL_HOUR;
            if (wr_en && ptr == OFS_AL_DAY) al_day <= shreg & MSK_AL_DAY;
            if (wr_en && ptr == OFS_AL_WDAY) al_wday <= shreg & MSK_AL_WDAY;
            // A new tick wins over the one consumed in the same cycle
            pend <= tick | (pend & ~apply); // RULE_10
        end
    end

    // Alarm compare
    wire [3:0] dis = {al_wday[ALARM_DIS_BIT], al_day[ALARM_DIS_BIT],
                      al_hour[ALARM_DIS_BIT], al_min[ALARM_DIS_BIT]};
    wire [3:0] hit = {al_wday[2:0] == wday, al_day[5:0] == day[5:0],
                      al_hour[5:0] == hour[5:0], al_min[6:0] == min[6:0]}; // RULE_14
    wire match = (&(hit | dis)) & ~(&dis); // RULE_17
    wire af_set = moved & match & ~match_old; // RULE_16
    wire af_clr = wr_en & (ptr == OFS_CTRL2) & ~shreg[AF_BIT];

    always_ff @(posedge CLK_SYS_I)
    begin
        if (SRST_I)
        begin
            af <= 1'b0;
            moved <= 1'b0;
            match_old <= 1'b0;
        end
        else
        begin
            moved <= apply;
            if (apply) match_old <= match;
            af <= af_set | (af & ~af_clr); // RULE_15
        end
    end

    assign SDA_O = 1'b0;
    assign SDA_OE_N_O = ~sda_pull;
    assign ALARM_HIT_O = af;

    a_frozen_access: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // RULE_09
        busy && !wr_en |=> $stable(sec) && $stable(day) && $stable(year))
        else $error("time moved during an access");
    a_tick_held: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // RULE_10
        tick && busy |=> pend)
        else $error("tick lost during an access");
    a_leap_feb: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // RULE_02
        apply && c_day && day == 8'h28 && month[4:0] == 5'h02 && year == 8'h00 |=> day == 8'h29)
        else $error("leap day skipped");
    a_century_flip: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // RULE_05
        apply && c_cent |=> year == 8'h00 && month[CENTURY_BIT] != $past(month[CENTURY_BIT]))
        else $error("century flag not toggled");
    a_wday_wrap: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // RULE_20
        apply && c_day && wday == 3'h6 |=> wday == 3'h0)
        else $error("weekday did not wrap");
    a_month_wrap: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // RULE_19
        apply && c_year |=> month[4:0] == 5'h01 && day == 8'h01)
        else $error("month or day did not wrap");
    a_flag_sticky: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // RULE_15
        af && !af_clr |=> af)
        else $error("alarm flag dropped");
    a_flag_cause: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // RULE_16
        !af ##1 af |-> $past(moved) && $past(match) && !$past(match_old))
        else $error("alarm flag set without new match");
    a_all_disabled: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I) // RULE_17
        &dis |-> !af_set)
        else $error("alarm set with every field disabled");

endmodule : calendar_date_alarm_core

`default_nettype wire

// file: dv/serial_host_model.sv
// Purpose: Behavioural two-wire bus master that drives the calendar core
// Assumes: The bench resolves the open-drain data wire with a pull-up
// Notes: Signals change just after a system clock rising edge, never on the far edge
`timescale 1ns/1ps
`default_nettype none
module serial_host_model
#(
    parameter int QTR = 5
)
(
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    initial
    begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic wait_q(input int n);
        repeat (n * QTR) @(posedge clk_i);
    endtask : wait_q
    task automatic put_bit(input logic b);
        sda_low_o <= ~b;
        wait_q(1);
        scl_o <= 1'b1;
        wait_q(2);
        scl_o <= 1'b0;
        wait_q(1);
    endtask : put_bit
    // Data is released before the clock rises so the device may drive it
    task automatic get_bit(output logic b);
        sda_low_o <= 1'b0;
        wait_q(1);
        scl_o <= 1'b1;
        wait_q(1);
        b = sda_i;
        wait_q(1);
        scl_o <= 1'b0;
        wait_q(1);
    endtask : get_bit
    task automatic start_cond();
        sda_low_o <= 1'b0;
        wait_q(1);
        scl_o <= 1'b1;
        wait_q(1);
        sda_low_o <= 1'b1;
        wait_q(1);
        scl_o <= 1'b0;
        wait_q(1);
    endtask : start_cond
    task automatic stop_cond();
        sda_low_o <= 1'b1;
        wait_q(1);
        scl_o <= 1'b1;
        wait_q(1);
        sda_low_o <= 1'b0;
        wait_q(2);
    endtask : stop_cond
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--)
            put_bit(d[i]);
        get_bit(a);
        ack = ~a;
    endtask : put_byte
    // A high acknowledge on the last byte ends the read
    task automatic get_byte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            get_bit(d[i]);
        put_bit(last);
    endtask : get_byte
endmodule : serial_host_model
`default_nettype wire

// file: dv/test_calendar_date_alarm_core.sv
// Purpose: Self-checking bench for the calendar, alarm and serial access core
// Assumes: The bench gates the oscillator so every tick lands in a known window
// Notes: Expected time comes from an integer calendar model
`timescale 1ns/1ps
`default_nettype none
module test_calendar_date_alarm_core;
    import rtc_cal_pkg::*;
    localparam int DIV = 8;
    localparam logic [7:0] MSK[7] = '{MSK_SEC, MSK_MIN, MSK_HOUR, MSK_DAY, MSK_WDAY, MSK_MONTH | 8'h80, 8'hff};
    localparam int ALM_T[9] = '{59, 29, 10, 7, 3, 6, 30, 0, 0};
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic clk_osc = 1'b0;
    logic osc_run = 1'b1;
    logic scl;
    logic host_low;
    logic sda_oe_n;
    logic sda_out;
    logic alarm_hit;
    wire logic sda = ~host_low & (sda_oe_n | sda_out);
    int mismatches = 0;
    int check_count = 0;
    int seed = 91;
    int tm[7];
    logic cent;
    int rows[8][9] = '{'{59, 59, 23, 31, 6, 12, 99, 0, 1}, '{59, 59, 23, 28, 2, 2, 24, 1, 2},
        '{59, 59, 23, 28, 3, 2, 23, 0, 1}, '{59, 59, 23, 28, 4, 2, 0, 0, 1}, '{59, 59, 23, 29, 5, 2, 4, 0, 1},
        '{58, 59, 23, 30, 0, 9, 50, 0, 1}, '{default: 0}, '{default: 0}};
    always #20 clk_sys = ~clk_sys;
    initial
    begin
        #13;
        forever
        begin
            #40;
            if (osc_run)
                clk_osc = ~clk_osc;
        end
    end
    calendar_date_alarm_core #(.TICK_DIV(DIV)) DUT (.CLK_SYS_I(clk_sys), .SRST_I(srst), .CLK_OSC_I(clk_osc),
        .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_out), .SDA_OE_N_O(sda_oe_n), .ALARM_HIT_O(alarm_hit));
    serial_host_model host (.clk_i(clk_sys), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic flag(input logic e);
        check({7'h0, alarm_hit}, {7'h0, e});
    endtask : flag
    task automatic close_out();
        $display("mismatches %0d check_count %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    function automatic int rnd(input int n);
        return ($random(seed) & 32'h7fff) % n;
    endfunction : rnd
    function automatic logic [7:0] bcd(input int v);
        return 8'((v / 10) * 16 + v % 10);
    endfunction : bcd
    function automatic int dim(input int m, input int y);
        if (m == 2)
            return (y % 4 == 0) ? 29 : 28;
        return (m == 4 || m == 6 || m == 9 || m == 11) ? 30 : 31;
    endfunction : dim
    task automatic advance();
        tm[0] = (tm[0] + 1) % 60;
        if (tm[0] == 0)
            tm[1] = (tm[1] + 1) % 60;
        if (tm[0] + tm[1] == 0)
            tm[2] = (tm[2] + 1) % 24;
        if (tm[0] + tm[1] + tm[2] == 0)
        begin
            tm[4] = (tm[4] + 1) % 7;
            tm[3] = tm[3] % dim(tm[5], tm[6]) + 1;
            if (tm[3] == 1)
                tm[5] = tm[5] % 12 + 1;
            if (tm[3] == 1 && tm[5] == 1)
                tm[6] = (tm[6] + 1) % 100;
            if (tm[3] == 1 && tm[5] == 1 && tm[6] == 0)
                cent = ~cent;
        end
    endtask : advance
    // Each window of DIV oscillator edges holds exactly one tick
    task automatic tick(input int n);
        osc_run = 1'b1;
        repeat (n * DIV) @(posedge clk_osc);
        osc_run = 1'b0;
        repeat (20) @(posedge clk_sys);
    endtask : tick
    task automatic send(input logic [7:0] d);
        logic a;
        host.put_byte(d, a);
        check({7'h0, a}, 8'h01);
    endtask : send
    task automatic open_at(input logic [3:0] ptr);
        host.start_cond();
        send({DEV_ADDR, 1'b0});
        send({4'h0, ptr});
    endtask : open_at
    task automatic wr(input logic [3:0] ptr, input logic [7:0] q[$], input int nt);
        open_at(ptr);
        foreach (q[i])
            send(q[i]);
        if (nt > 0)
            tick(nt);
        host.stop_cond();
    endtask : wr
    task automatic rd(input logic [3:0] ptr, input int n, input int nt, output logic [7:0] r[$]);
        logic [7:0] d;
        r = {};
        open_at(ptr);
        host.start_cond();
        send({DEV_ADDR, 1'b1});
        for (int i = 0; i < n; i++)
        begin
            host.get_byte(i == n - 1, d);
            r.push_back(d);
            if (i == 0 && nt > 0)
                tick(nt);
        end
        host.stop_cond();
    endtask : rd
    task automatic set_time(input int v[9]);
        logic [7:0] q[$];
        for (int i = 0; i < 7; i++)
        begin
            tm[i] = v[i];
            q.push_back(bcd(v[i]));
        end
        cent = v[7][0];
        q[5][7] = cent;
        wr(OFS_SEC, q, v[8]);
        if (v[8] > 0)
            advance();
    endtask : set_time
    task automatic verify(input int nt);
        logic [7:0] r[$];
        logic [7:0] e;
        rd(OFS_SEC, 7, nt, r);
        foreach (r[i])
        begin
            e = bcd(tm[i]);
            if (i == 5)
                e[7] = cent;
            check(r[i] & MSK[i], e);
        end
        if (nt > 0)
            advance();
    endtask : verify
    initial
    begin
        repeat (90000) @(posedge clk_sys);
        mismatches++;
        close_out();
    end
    initial
    begin
        logic [7:0] r[$];
        logic a;
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (2 * DIV) @(posedge clk_osc);
        osc_run = 1'b0;
        repeat (20) @(posedge clk_sys);
        flag(1'b0);
        rd(OFS_DAY, 8, 0, r);
        foreach (r[i])
            check(r[i], (i == 1 || i == 3) ? 8'h00 : ((i < 4) ? RST_DATE : RST_ALARM));
        for (int k = 0; k < 8; k++)
        begin
            if (k >= 6)
                rows[k] = '{rnd(59), rnd(60), rnd(24), rnd(28) + 1, rnd(7), rnd(12) + 1, rnd(100), rnd(2), 1};
            set_time(rows[k]);
            verify(1);
            // Row 5 reads 23:59:59 while a tick waits, so a carry mid-read would show
            if (k == 0 || k == 5)
                verify(0);
        end
        wr(4'hd, '{8'hff}, 0);
        rd(4'hd, 1, 0, r);
        check(r[0], 8'h00);
        host.start_cond();
        host.put_byte(8'ha0, a);
        check({7'h0, a}, 8'h00);
        host.stop_cond();
        wr(OFS_AL_MIN, '{8'h30, 8'h10, 8'h85, 8'h04}, 0);
        set_time(ALM_T);
        tick(1);
        flag(1'b0);
        wr(OFS_AL_WDAY, '{8'h03}, 0);
        set_time(ALM_T);
        tick(1);
        flag(1'b1);
        rd(OFS_CTRL2, 1, 0, r);
        check(r[0], 8'h08);
        tick(1);
        flag(1'b1);
        wr(OFS_CTRL2, '{8'h00}, 0);
        flag(1'b0);
        tick(1);
        flag(1'b0);
        set_time(ALM_T);
        tick(1);
        flag(1'b1);
        close_out();
    end
endmodule : test_calendar_date_alarm_core
`default_nettype wire
